// File: rtl/fdc_command_word.sv
// fdc_command_word: decodes the fieldbus command word into drive commands.
// assumes command_word and I/O pins are asynchronous; drive feedback is
// on ref_clk. a write strobe marks each fieldbus update.
//
// Summary of operation
// RQ1: switch-on rising edge clears inhibit and goes to ready-to-run.
// RQ2: switch-on low makes a ramped stop then ready-to-switch-on.
// RQ3: coast-stop low coasts and enters switch-on inhibit.
// RQ4: quick-stop low runs the configured quick stop function.
// RQ5: start bit high runs the drive, low stops with stop function.
// RQ6: ramp-enable low zeroes ramp output; overrides freeze and setpoint.
// RQ7: ramp-freeze low holds speed and ignores references; beats setpoint.
// RQ8: setpoint-enable low zeroes reference; lowest ramp priority.
// RQ9: faults acknowledged only on a rising edge of fault-reset.
// RQ10: acknowledged fault with voltage removed goes to switch-on inhibit.
// RQ11: start with all ramp bits zero is a fieldbus jog request.
// RQ12: fieldbus jog accepted at zero speed; ramp bits resume at zero.
// RQ13: jog bits select jog references, only when jogging is enabled.
// RQ14: I/O jog starts without start command, needs jog-enable input.
// RQ15: jog requests ignored while a start command is active.
// RQ16: both jog references requested together stops the drive.
// RQ17: fieldbus enable counts only with fieldbus place; else word ignored (ramp_mode still follows the ramp bits).
// RQ18: removing fieldbus enable while running makes a coasting stop.
// RQ19: master toggles the alive bit with about one second period.
// RQ20: missing alive toggles raise a fieldbus communication fault.
// RQ21: nonzero watchdog delay enables supervision; zero disables it.
// RQ22: received alive bit is echoed in status bit fifteen.
// RQ23: word sampled per update; edges found against previous sample.
module fdc_command_word
	import fdc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [fdc_pkg::CW_W-1:0] fieldbus_command_word,
	input wire logic fieldbus_update,
	input wire logic [1:0] control_place_select,
	input wire logic [fdc_pkg::WD_DLY_W-1:0] watchdog_delay_setting,
	input wire logic aux_jog_enable,
	input wire logic io_jog_enable,
	input wire logic io_jog1,
	input wire logic io_jog2,
	input wire logic fault_active,
	input wire logic fault_voltage_removed,
	input wire logic at_zero_speed,
	output fdc_pkg::fdc_state_t drive_state,
	output fdc_pkg::fdc_ramp_t ramp_mode,
	output fdc_pkg::fdc_stop_t stop_mode,
	output logic run_cmd,
	output logic jog_ref1_sel,
	output logic jog_ref2_sel,
	output logic fault_ack,
	output logic comm_fault,
	output logic fieldbus_active,
	output logic [fdc_pkg::CW_W-1:0] status_echo
);
	logic [CW_W-1:0] cw_sync;
	logic upd_sync;
	logic [2:0] io_sync;
	logic upd_q;
	logic [CW_W-1:0] cw;
	logic [CW_W-1:0] cw_prev;
	logic [CW_W-1:0] next_cw;
	logic [CW_W-1:0] next_cw_prev;
	logic wd_timeout;
	logic fb_place;
	logic fb_en;
	logic on_rise;
	logic ack_rise;
	logic fb_jog_req;
	logic io_jog_req;
	logic both_jogs;
	logic start_req;
	fdc_state_t next_state;
	fdc_ramp_t next_ramp;
	fdc_stop_t next_stop;
	logic next_run;
	logic next_j1;
	logic next_j2;
	logic next_ack;
	logic next_comm;
	logic next_fb_active;
	logic [CW_W-1:0] next_echo;

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	// bus word and strobe come from the fieldbus board clock
	fdc_sync #(.W(CW_W + 1)) u_sync_cw (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.din({fieldbus_update, fieldbus_command_word}),
		.dout({upd_sync, cw_sync})
	);

	// I/O terminal jog pins
	fdc_sync #(.W(3)) u_sync_io (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.din({io_jog_enable, io_jog1, io_jog2}),
		.dout(io_sync)
	);

	// ----------------------------------------------------------------
	// link supervision
	// ----------------------------------------------------------------
	fdc_watchdog u_wd (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.alive(cw[B_ALIVE]),
		.watchdog_delay_setting(watchdog_delay_setting),
		.timeout(wd_timeout)
	);

	// ----------------------------------------------------------------
	// command word sampling
	// ----------------------------------------------------------------
	// one sample per update strobe rising edge; previous kept for edges
	always_comb begin
		next_cw = cw;
		next_cw_prev = cw_prev;
		if (upd_sync && !upd_q) begin
			next_cw = cw_sync; // RQ23
			next_cw_prev = cw; // RQ23
		end else begin
			next_cw_prev = cw; // edge seen for one cycle only
		end
	end

	// register samples
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			upd_q <= 1'b0;
			cw <= CW_RESET;
			cw_prev <= CW_RESET;
		end else if (clk_en) begin
			upd_q <= upd_sync;
			cw <= next_cw;
			cw_prev <= next_cw_prev;
		end
	end

	// ----------------------------------------------------------------
	// request decode
	// ----------------------------------------------------------------
	// word only counts with fieldbus place selected and enable set
	assign fb_place = control_place_select == PLACE_FIELDBUS;
	assign fb_en = fb_place && cw[B_FB_EN]; // RQ17
	assign on_rise = fb_en && cw[B_SWITCH_ON] && !cw_prev[B_SWITCH_ON];
	assign ack_rise = fb_en && cw[B_FAULT_ACK] && !cw_prev[B_FAULT_ACK]; // RQ9
	// start with all ramp bits zero means a jog
	assign fb_jog_req = fb_en && cw[B_START] && !cw[B_RAMP_EN]
		&& !cw[B_RAMP_RUN] && !cw[B_SETP_EN]; // RQ11
	assign start_req = fb_en && cw[B_START] && !fb_jog_req;
	// I/O jog needs its enable input, any control place
	assign io_jog_req = io_sync[2] && (io_sync[1] || io_sync[0]); // RQ14
	assign both_jogs = (fb_jog_req && aux_jog_enable
		&& cw[B_JOG1] && cw[B_JOG2])
		|| (io_jog_req && io_sync[1] && io_sync[0]); // RQ16

	// ----------------------------------------------------------------
	// drive state machine
	// ----------------------------------------------------------------
	// priority: comm fault, fault, coast, quick stop, then normal
	always_comb begin
		next_state = drive_state;
		next_stop = STOP_NONE;
		next_run = 1'b0;
		next_j1 = 1'b0;
		next_j2 = 1'b0;
		next_ack = ack_rise;
		next_comm = comm_fault || wd_timeout; // RQ20
		next_fb_active = fb_en;
		case (drive_state)
			ST_FAULT: begin
				if (ack_rise) begin
					next_comm = wd_timeout;
					if (fault_voltage_removed)
						next_state = ST_INHIBIT; // RQ10
					else
						next_state = ST_READY_ON;
				end
			end
			ST_INHIBIT: begin
				if (on_rise && cw[B_COAST_N] && cw[B_QSTOP_N])
					next_state = ST_READY_RUN; // RQ1
			end
			ST_READY_ON: begin
				if (on_rise)
					next_state = ST_READY_RUN; // RQ1
			end
			ST_READY_RUN: begin
				if (io_jog_req && !both_jogs) begin
					next_state = ST_JOG; // RQ14
				end else if (fb_en && !cw[B_SWITCH_ON]) begin
					next_state = ST_READY_ON;
				end else if (fb_jog_req && aux_jog_enable && at_zero_speed
					&& (cw[B_JOG1] ^ cw[B_JOG2])) begin
					next_state = ST_JOG; // RQ12
				end else if (start_req) begin
					next_state = ST_RUN; // RQ5
				end
			end
			ST_RUN: begin
				next_run = 1'b1;
				if (fieldbus_active && !fb_en) begin
					next_stop = STOP_COAST; // RQ18
					next_state = ST_INHIBIT;
				end else if (!cw[B_SWITCH_ON]) begin
					next_stop = STOP_RAMP; // RQ2
					next_state = ST_READY_ON;
				end else if (!start_req) begin
					next_stop = STOP_RAMP; // RQ5
					next_state = ST_READY_RUN;
				end
			end
			ST_JOG: begin
				// jog ignored once a real start is present
				next_run = !start_req && !both_jogs; // RQ15
				next_j1 = io_jog_req ? io_sync[1] : cw[B_JOG1]; // RQ13
				next_j2 = io_jog_req ? io_sync[0] : cw[B_JOG2]; // RQ13
				if (start_req || both_jogs
					|| (!io_jog_req && !fb_jog_req)) begin
					next_stop = STOP_RAMP; // RQ16
					next_j1 = 1'b0;
					next_j2 = 1'b0;
					// ramp bits resume only once speed reaches zero
					if (at_zero_speed)
						next_state = ST_READY_RUN; // RQ12
				end
			end
			default: next_state = ST_INHIBIT;
		endcase
		if (drive_state != ST_FAULT) begin
			if (fault_active || next_comm) begin
				next_state = ST_FAULT; // RQ20
				next_run = 1'b0;
			end else if (fb_en && !cw[B_COAST_N]) begin
				next_stop = STOP_COAST; // RQ3
				next_state = ST_INHIBIT;
				next_run = 1'b0;
			end else if (fb_en && !cw[B_QSTOP_N]) begin
				next_stop = STOP_QUICK; // RQ4
				next_state = ST_INHIBIT;
				next_run = 1'b0;
			end
		end
		// ramp control priority: enable, then freeze, then setpoint
		if (!cw[B_RAMP_EN])
			next_ramp = RAMP_ZERO; // RQ6
		else if (!cw[B_RAMP_RUN])
			next_ramp = RAMP_HOLD; // RQ7
		else if (!cw[B_SETP_EN])
			next_ramp = RAMP_SETP_ZERO; // RQ8
		else
			next_ramp = RAMP_FOLLOW;
		if (drive_state == ST_JOG)
			next_ramp = RAMP_FOLLOW;
		next_echo = '0;
		next_echo[B_ECHO] = cw[B_ALIVE]; // RQ22
	end

	// register state and outputs
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			drive_state <= ST_INHIBIT;
			ramp_mode <= RAMP_ZERO;
			stop_mode <= STOP_NONE;
			run_cmd <= 1'b0;
			jog_ref1_sel <= 1'b0;
			jog_ref2_sel <= 1'b0;
			fault_ack <= 1'b0;
			comm_fault <= 1'b0;
			fieldbus_active <= 1'b0;
			status_echo <= CW_RESET;
		end else if (clk_en) begin
			drive_state <= next_state;
			ramp_mode <= next_ramp;
			stop_mode <= next_stop;
			run_cmd <= next_run;
			jog_ref1_sel <= next_j1;
			jog_ref2_sel <= next_j2;
			fault_ack <= next_ack;
			comm_fault <= next_comm;
			fieldbus_active <= next_fb_active;
			status_echo <= next_echo;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_ramp_zero_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && !cw[B_RAMP_EN] && drive_state != ST_JOG
		|=> ramp_mode == RAMP_ZERO) // RQ6
		else $error("ramp enable low did not zero ramp");
	a_hold_over_setp: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && cw[B_RAMP_EN] && !cw[B_RAMP_RUN] && drive_state != ST_JOG
		|=> ramp_mode == RAMP_HOLD) // RQ7
		else $error("freeze did not hold ramp");
	a_setp_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && cw[B_RAMP_EN] && cw[B_RAMP_RUN] && !cw[B_SETP_EN]
		&& drive_state != ST_JOG |=> ramp_mode == RAMP_SETP_ZERO) // RQ8
		else $error("setpoint disable not applied");
	a_ack_on_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en |=> fault_ack == $past(ack_rise)) // RQ9
		else $error("fault acknowledge not tied to rising edge");
	a_coast_inhibit: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && fb_en && !cw[B_COAST_N] && drive_state != ST_FAULT
		&& !fault_active && !wd_timeout && !comm_fault
		|=> drive_state == ST_INHIBIT && stop_mode == STOP_COAST) // RQ3
		else $error("coast stop did not inhibit");
	a_echo_alive: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en |=> status_echo[B_ECHO] == $past(cw[B_ALIVE])) // RQ22
		else $error("alive bit not echoed");
	a_ignore_word: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && !fb_en && drive_state == ST_READY_RUN && !io_jog_req
		&& !fault_active && !wd_timeout
		|=> drive_state == ST_READY_RUN) // RQ17
		else $error("command word acted while not enabled");
	a_fault_to_inh: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && drive_state == ST_FAULT && ack_rise && fault_voltage_removed
		|=> drive_state == ST_INHIBIT) // RQ10
		else $error("acknowledged fault did not inhibit");
	a_no_dual_jog: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && drive_state == ST_JOG && both_jogs |=> !run_cmd) // RQ16
		else $error("drive ran with both jog references");
	a_comm_fault: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && wd_timeout |=> comm_fault) // RQ20
		else $error("watchdog timeout missed");
	a_on_rise_ready: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && drive_state == ST_INHIBIT && on_rise && cw[B_COAST_N]
		&& cw[B_QSTOP_N] && !fault_active && !wd_timeout && !comm_fault
		|=> drive_state == ST_READY_RUN) // RQ1
		else $error("switch-on rise did not leave inhibit");
	c_run: cover property (@(posedge ref_clk) drive_state == ST_RUN);
	c_jog: cover property (@(posedge ref_clk) drive_state == ST_JOG);
	c_fault_ack: cover property (@(posedge ref_clk)
		drive_state == ST_FAULT ##1 drive_state == ST_INHIBIT);
	c_coast: cover property (@(posedge ref_clk) stop_mode == STOP_COAST);
endmodule : fdc_command_word

// File: shared/fdc_pkg.sv
// fdc_pkg: constants and types shared by the fieldbus command word decoder.
// assumes a 40 MHz ref_clk; watchdog delay is counted in milliseconds.
package fdc_pkg;
	// ----------------------------------------------------------------
	// command word layout
	// ----------------------------------------------------------------
	localparam int CW_W = 16;
	localparam int B_SWITCH_ON = 0;
	localparam int B_COAST_N = 1;
	localparam int B_QSTOP_N = 2;
	localparam int B_START = 3;
	localparam int B_RAMP_EN = 4;
	localparam int B_RAMP_RUN = 5;
	localparam int B_SETP_EN = 6;
	localparam int B_FAULT_ACK = 7;
	localparam int B_JOG1 = 8;
	localparam int B_JOG2 = 9;
	localparam int B_FB_EN = 10;
	localparam int B_ALIVE = 11;
	localparam int B_ECHO = 15;
	localparam logic [CW_W-1:0] CW_RESET = 16'h0000;
	// ----------------------------------------------------------------
	// control place and timing
	// ----------------------------------------------------------------
	localparam logic [1:0] PLACE_FIELDBUS = 2'h3;
	localparam int CLK_HZ = 40_000_000;
	localparam int WD_MS = 1;
	localparam int WD_TICK = CLK_HZ / 1000 * WD_MS;
	localparam int WD_DLY_W = 16;
	localparam int TICK_W = 16;
	// ----------------------------------------------------------------
	// drive states and ramp modes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_INHIBIT, ST_READY_ON, ST_READY_RUN, ST_RUN, ST_JOG, ST_FAULT
	} fdc_state_t;
	typedef enum logic [1:0] {
		RAMP_ZERO, RAMP_HOLD, RAMP_SETP_ZERO, RAMP_FOLLOW
	} fdc_ramp_t;
	typedef enum logic [1:0] {
		STOP_NONE, STOP_RAMP, STOP_COAST, STOP_QUICK
	} fdc_stop_t;
endpackage : fdc_pkg

// File: rtl/fdc_sync.sv
// fdc_sync: two flip-flop synchroniser for a bus of pin-level inputs.
// assumes inputs are asynchronous to ref_clk; output is the second stage.
module fdc_sync #(
	parameter int W = 1
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_dout;

	// ----------------------------------------------------------------
	// stages
	// ----------------------------------------------------------------
	// first stage feeds only the second
	always_comb begin
		next_meta = clk_en ? din : meta;
		next_dout = clk_en ? meta : dout;
	end

	// register both stages, cleared by reset
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			meta <= '0;
			dout <= '0;
		end else begin
			meta <= next_meta;
			dout <= next_dout;
		end
	end
endmodule : fdc_sync

// File: rtl/fdc_watchdog.sv
// fdc_watchdog: supervises toggling of the link-alive pulse.
// assumes alive is sampled once per fieldbus update in ref_clk domain.
module fdc_watchdog
	import fdc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic alive,
	input wire logic [fdc_pkg::WD_DLY_W-1:0] watchdog_delay_setting,
	output logic timeout
);
	logic alive_q;
	logic [TICK_W-1:0] tick;
	logic [WD_DLY_W-1:0] ms;
	logic [TICK_W-1:0] next_tick;
	logic [WD_DLY_W-1:0] next_ms;
	logic next_alive_q;
	logic next_timeout;

	// ----------------------------------------------------------------
	// delay counting
	// ----------------------------------------------------------------
	// any edge of the pulse restarts the delay; zero delay disables it
	always_comb begin
		next_alive_q = alive_q;
		next_tick = tick;
		next_ms = ms;
		next_timeout = timeout;
		if (clk_en) begin
			next_alive_q = alive;
			if (watchdog_delay_setting == '0) begin // RQ21
				next_tick = '0;
				next_ms = '0;
				next_timeout = 1'b0;
			end else if (alive != alive_q) begin
				// a live pulse clears a stale timeout
				next_timeout = 1'b0;
				next_tick = '0;
				next_ms = '0;
			end else if (ms >= watchdog_delay_setting) begin
				next_timeout = 1'b1; // RQ20
			end else if (tick == TICK_W'(WD_TICK - 1)) begin
				next_tick = '0;
				next_ms = ms + 1'b1;
			end else begin
				next_tick = tick + 1'b1;
			end
		end
	end

	// register counters
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			alive_q <= 1'b0;
			tick <= '0;
			ms <= '0;
			timeout <= 1'b0;
		end else begin
			alive_q <= next_alive_q;
			tick <= next_tick;
			ms <= next_ms;
			timeout <= next_timeout;
		end
	end

	a_wd_off_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
		watchdog_delay_setting == '0 && clk_en |=> !timeout) // RQ21
		else $error("watchdog timed out while disabled");
endmodule : fdc_watchdog

// File: verif/fdc_master.sv
// fdc_master: behavioural fieldbus master that writes the command word.
// assumes the bench asks for one update at a time through send and done.
module fdc_master
	import fdc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic send,
	input wire logic [fdc_pkg::CW_W-1:0] word_in,
	input wire logic alive_en,
	output logic [fdc_pkg::CW_W-1:0] fieldbus_command_word,
	output logic fieldbus_update,
	output logic alive_bit,
	output logic done
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------------------------------
	// update frames
	// ----------------------------------------------------------------
	initial begin
		fieldbus_command_word = 16'h0000;
		fieldbus_update = 1'b0;
		alive_bit = 1'b0;
		done = 1'b0;
	end
	// word stands six cycles around a three cycle strobe, then goes stale
	always begin
		@(posedge ref_clk);
		if (send) begin
			#1;
			if (alive_en) begin
				alive_bit = ~alive_bit;
			end
			fieldbus_command_word = word_in;
			fieldbus_command_word[B_ALIVE] = alive_bit;
			fieldbus_update = 1'b1;
			repeat (3) @(posedge ref_clk);
			#1 fieldbus_update = 1'b0;
			repeat (3) @(posedge ref_clk);
			// no longer valid: show the inverse, not the last word
			#1 fieldbus_command_word = ~fieldbus_command_word;
			done = 1'b1;
			@(posedge ref_clk);
			#1 done = 1'b0;
		end
	end
endmodule : fdc_master

// File: verif/tb.sv
// tb: self-checking bench for the command word decoder.
// assumes fdc_master supplies the word; bench drives pins and feedback.
module tb;
	import fdc_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic send = 1'b0;
	logic alive_en = 1'b1;
	logic [15:0] word_in = 16'h0000;
	logic [15:0] cw;
	logic upd, alive_bit, done;
	logic [1:0] place = 2'h3;
	logic [15:0] wd_dly = 16'h0000;
	logic aux_jog = 1'b0;
	logic io_en = 1'b0;
	logic io_j1 = 1'b0;
	logic io_j2 = 1'b0;
	logic f_act = 1'b0;
	logic f_vrem = 1'b0;
	logic zero_spd = 1'b1;
	logic ce = 1'b1;
	fdc_state_t drive_state;
	fdc_ramp_t ramp_mode;
	fdc_stop_t stop_mode;
	fdc_stop_t last_stop = STOP_NONE;
	logic run_cmd, jog1, jog2, fault_ack, comm_fault, fb_act;
	logic [15:0] status_echo;
	int miscompares = 0;
	int checks_done = 0;
	int ack_cnt = 0;
	logic [15:0] rw [4] = '{16'h046F, 16'h045F, 16'h043F, 16'h047F};
	fdc_ramp_t rm [4] = '{RAMP_ZERO, RAMP_HOLD, RAMP_SETP_ZERO, RAMP_FOLLOW};
	// ----------------------------------------------------------------
	// clock, partner and design
	// ----------------------------------------------------------------
	always #12.5 ref_clk = ~ref_clk;
	fdc_master i_fdc_master (.ref_clk(ref_clk), .send(send),
		.word_in(word_in), .alive_en(alive_en),
		.fieldbus_command_word(cw), .fieldbus_update(upd),
		.alive_bit(alive_bit), .done(done));
	fdc_command_word i_fdc_command_word (.ref_clk(ref_clk),
		.rst_n(rst_n), .clk_en(ce), .fieldbus_command_word(cw),
		.fieldbus_update(upd), .control_place_select(place),
		.watchdog_delay_setting(wd_dly), .aux_jog_enable(aux_jog),
		.io_jog_enable(io_en), .io_jog1(io_j1), .io_jog2(io_j2),
		.fault_active(f_act), .fault_voltage_removed(f_vrem),
		.at_zero_speed(zero_spd), .drive_state(drive_state),
		.ramp_mode(ramp_mode), .stop_mode(stop_mode), .run_cmd(run_cmd),
		.jog_ref1_sel(jog1), .jog_ref2_sel(jog2), .fault_ack(fault_ack),
		.comm_fault(comm_fault), .fieldbus_active(fb_act),
		.status_echo(status_echo));
	// catch one-cycle stop and acknowledge pulses
	always @(posedge ref_clk) begin
		if (stop_mode !== STOP_NONE) last_stop = stop_mode;
		if (fault_ack === 1'b1) ack_cnt++;
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic end_sim();
		if (miscompares == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : wt
	// one update through the master, bounded wait for its end
	task automatic sendw(input logic [15:0] w);
		int n;
		n = 0;
		last_stop = STOP_NONE;
		word_in = w;
		send = 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (done !== 1'b1 && n < 50);
		#1 send = 1'b0;
		// a hung master ends the run as a failure
		if (n >= 50) begin
			miscompares++;
			end_sim();
		end
		// let an edge pass before any next request
		wt(1);
	endtask : sendw
	task automatic step(input logic [15:0] w, input fdc_state_t st);
		sendw(w);
		chk("drive_state", 16'(drive_state), 16'(st));
		chk("status_echo", status_echo, {alive_bit, 15'h0000});
	endtask : step
	// inhibit cleared by a switch-on rise with both stop bits high
	task automatic recover();
		step(16'h0476, ST_INHIBIT);
		step(16'h0477, ST_READY_RUN);
	endtask : recover
	// ----------------------------------------------------------------
	// watchdog and main sequence
	// ----------------------------------------------------------------
	initial begin
		#2400000;
		miscompares++;
		end_sim();
	end
	initial begin
		wt(5);
		rst_n = 1'b1;
		wt(3);
		chk("reset_state", 16'(drive_state), 16'(ST_INHIBIT));
		step(16'h0007, ST_INHIBIT);
		chk("fb_active", 16'(fb_act), 16'h0000);
		recover();
		chk("fb_active", 16'(fb_act), 16'h0001);
		step(16'h047F, ST_RUN);
		chk("run_cmd", 16'(run_cmd), 16'h0001);
		for (int i = 0; i < 4; i++) begin
			sendw(rw[i]);
			chk("ramp_mode", 16'(ramp_mode), 16'(rm[i]));
		end
		sendw(16'h0477);
		chk("run_cmd", 16'(run_cmd), 16'h0000);
		step(16'h047F, ST_RUN);
		step(16'h047D, ST_INHIBIT);
		chk("stop_mode", 16'(last_stop), 16'(STOP_COAST));
		recover();
		step(16'h047F, ST_RUN);
		step(16'h047B, ST_INHIBIT);
		chk("stop_mode", 16'(last_stop), 16'(STOP_QUICK));
		recover();
		step(16'h047F, ST_RUN);
		step(16'h047E, ST_READY_ON);
		chk("stop_mode", 16'(last_stop), 16'(STOP_RAMP));
		// fault, acknowledge on the rise only, voltage removed
		f_act = 1'b1;
		f_vrem = 1'b1;
		step(16'h0477, ST_FAULT);
		sendw(16'h04F7);
		chk("ack_count", 16'(ack_cnt), 16'h0001);
		f_act = 1'b0;
		// steady high does nothing; a fresh rise acknowledges
		step(16'h04F7, ST_FAULT);
		chk("ack_count", 16'(ack_cnt), 16'h0001);
		step(16'h0477, ST_FAULT);
		step(16'h04F7, ST_INHIBIT);
		chk("ack_count", 16'(ack_cnt), 16'h0002);
		f_vrem = 1'b0;
		recover();
		step(16'h047F, ST_RUN);
		sendw(16'h007F);
		chk("stop_mode", 16'(last_stop), 16'(STOP_COAST));
		chk("fb_active", 16'(fb_act), 16'h0000);
		recover();
		// fieldbus jog: start with all ramp bits low
		step(16'h050F, ST_READY_RUN);
		aux_jog = 1'b1;
		zero_spd = 1'b0;
		step(16'h050F, ST_READY_RUN);
		zero_spd = 1'b1;
		step(16'h050F, ST_JOG);
		chk("jog1", 16'(jog1), 16'h0001);
		sendw(16'h070F);
		chk("run_cmd", 16'(run_cmd), 16'h0000);
		step(16'h0407, ST_READY_RUN);
		aux_jog = 1'b0;
		// terminal jog
		io_j2 = 1'b1;
		wt(10);
		chk("run_cmd", 16'(run_cmd), 16'h0000);
		step(16'h047F, ST_RUN);
		io_en = 1'b1;
		wt(10);
		chk("jog2", 16'(jog2), 16'h0000);
		sendw(16'h0477);
		wt(10);
		chk("run_cmd", 16'(run_cmd), 16'h0001);
		chk("jog2", 16'(jog2), 16'h0001);
		io_j1 = 1'b1;
		wt(10);
		chk("run_cmd", 16'(run_cmd), 16'h0000);
		io_j1 = 1'b0;
		io_j2 = 1'b0;
		io_en = 1'b0;
		// frozen clock enable: an update is not seen
		ce = 1'b0;
		sendw(16'h047F);
		ce = 1'b1;
		wt(4);
		chk("frozen_state", 16'(drive_state), 16'(ST_READY_RUN));
		// alive pulse frozen: silent with zero delay, fault with 1 ms
		sendw(16'h0477);
		alive_en = 1'b0;
		wt(41000);
		chk("comm_fault", 16'(comm_fault), 16'h0000);
		wd_dly = 16'h0001;
		for (int n = 0; n < 50000 && comm_fault !== 1'b1; n++) wt(1);
		chk("comm_fault", 16'(comm_fault), 16'h0001);
		wt(2);
		chk("drive_state", 16'(drive_state), 16'(ST_FAULT));
		end_sim();
	end
endmodule : tb
